// File: core/vfd_defines.svh
/*
  Timing counts, field positions and reset values for the display driver.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef VFD_DEFINES_SVH
`define VFD_DEFINES_SVH

`define VFD_SEG_W 32
`define VFD_DIM_W 10
`define VFD_SHIFT_W 35
`define VFD_OSC_PER_BIT 4
`define VFD_SLOT_BITS 1024
`define VFD_GRIDS 3
`define VFD_DIM_CLAMP 10'h3F8
`define VFD_DIM_RESET 10'h000
`define VFD_SEG_RESET 32'h0000_0000
`define VFD_BIT_DIV_RESET 2'h0

`endif

// File: core/vfd_pkg.sv
/*
  Types for the display driver: mode codes and the grid slot state.
  Assumes no other package.
*/
package vfd_pkg;

  // Mode code as received, first mode bit in the low position.
  typedef enum logic [2:0] {
    mode_all_t   = 3'h0,
    mode_grid_drive_one_n_t = 3'h1,
    mode_grid_drive_two_n_t = 3'h2,
    mode_grid_drive_three_n_t = 3'h3,
    mode_dim_t   = 3'h4
  } mode_code_t;

  // Grid slot, one bit changes per step except on the wrap from slot three to slot one.
  typedef enum logic [1:0] {
    slot_one_t   = 2'h0,
    slot_two_t   = 2'h1,
    slot_three_t = 2'h3
  } slot_t;

endpackage

// File: core/vfd_link_rx.sv
/*
  Serial receiver on the link shift clock: shift register and frame capture.
  Assumes the shift clock may also run while chip select is low; chip select
  falling is detected in the system domain, which then samples frame_word.
*/
`timescale 1ns/1ps
`include "vfd_defines.svh"

module vfd_link_rx #(
  parameter int SHIFT_W = `VFD_SHIFT_W
) (
  input wire logic shift_clock,             // Link shift clock.
  input wire logic link_rst,                // Reset, already held in this domain by the caller.
  input wire logic chip_select,             // Transfer window, high while open.
  input wire logic data_in,                 // Serial data level.
  output logic [SHIFT_W-1:0] frame_word     // Shift register contents.
);

  logic [SHIFT_W-1:0] shift_reg;
  logic [SHIFT_W-1:0] shift_next;

  //////////////////////////////////////////////////////////////////////////////
  // Newest bit enters at bit 0, so the last three bits are the mode field.
  always_comb begin
    shift_next = shift_reg;
    // (RL6) shift on edge
    // (RL5) window gating
    if (chip_select) begin
      shift_next = {shift_reg[SHIFT_W-2:0], data_in};
    end
  end

  // Reset is asynchronous here because this clock may be stopped at reset.
  always_ff @(posedge shift_clock or posedge link_rst) begin
    // (RL1) clear shifter
    if (link_rst) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign frame_word = shift_reg;

endmodule

// File: core/vfd_driver.sv
/*
  Master-mode triplex display controller: serial load, latches, multiplex
  and dimming. Assumes clock is the oscillator stand-in; the link signals
  arrive asynchronously and are synchronised before use.
*/
`timescale 1ns/1ps
`include "vfd_defines.svh"

// Operation
// (RL1) Reset clears shift register, segment latches and dimming latch to zero.
// (RL2) Dimming duty is zero after reset, giving no on-time.
// (RL3) All thirty-two segment outputs are low after reset.
// (RL4) After reset grid one output is low, grids two and three high.
// (RL5) Bits are accepted only while chip select is high.
// (RL6) Data level shifts in on each shift clock rising edge.
// (RL7) Host sends payload first, mode bits last, without gaps.
// (RL8) Chip select falling produces a load pulse into the selected latch.
// (RL9) Mode 000 all grids, 100/010/110 one grid, 001 dimming.
// (RL10) Mode zero writes the same pattern to all three segment latches.
// (RL11) Grid modes update only the addressed latch.
// (RL12) Segment bit one lights its output during its grid slot.
// (RL13) Segment frame is 35 bits: segments one to 32, then mode.
// (RL14) Display cycle is 3072 bit times, three equal 1024 slots.
// (RL15) Grid on-time equals dimming value in bit times.
// (RL16) Dimming value 64 gives 64 bit times on per slot.
// (RL17) Dimming frame is 13 bits, ten LSB-first then mode bits.
// (RL18) Dimming values 1016 and above clamp to 1016 bit times.
// (RL19) Undefined mode codes change no latch.
// (RL20) New latch content applies from the next slot boundary.
module vfd_driver #(
  parameter int SEG_W = `VFD_SEG_W,
  parameter int DIM_W = `VFD_DIM_W,
  parameter int SHIFT_W = `VFD_SHIFT_W
) (
  input wire logic clock,                   // Oscillator clock, 200 MHz.
  input wire logic sys_rst,                 // Synchronous reset, active high.
  input wire logic shift_clock,             // Link shift clock.
  input wire logic chip_select,             // Link chip select, high opens a transfer.
  input wire logic data_in,                 // Link serial data.
  output logic [SEG_W-1:0] anode_out,       // Segment outputs, high lit.
  output logic grid_drive_one_n,            // Grid one drive, active low.
  output logic grid_drive_two_n,            // Grid two drive, active low.
  output logic grid_drive_three_n,          // Grid three drive, active low.
  output logic dimming_pulse_out,           // High during the on-time.
  output logic slot_sync_out_a,             // Slot code bit a.
  output logic slot_sync_out_b,             // Slot code bit b.
  output logic [DIM_W-1:0] dim_level        // Current dimming latch.
);

  //////////////////////////////////////////////////////////////////////////////
  // Link-domain reset: two flops so release is clean on the shift clock.
  logic link_rst_meta_reg;
  logic link_rst_reg;
  logic [SHIFT_W-1:0] frame_word;

  always_ff @(posedge shift_clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst_meta_reg <= 1'b1;
      link_rst_reg <= 1'b1;
    end else begin
      link_rst_meta_reg <= 1'b0;
      link_rst_reg <= link_rst_meta_reg;
    end
  end

  vfd_link_rx #(
    .SHIFT_W(SHIFT_W)
  ) u_rx (
    .shift_clock(shift_clock),
    .link_rst(link_rst_reg),
    .chip_select(chip_select),
    .data_in(data_in),
    .frame_word(frame_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Chip select synchroniser. The shift word is stable after chip select
  // falls because the receiver shifts only while chip select is high, so the word crosses
  // under that handshake once the synchronised fall is seen.
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic [SHIFT_W-1:0] word_meta_reg;
  logic [SHIFT_W-1:0] word_sync_reg;
  logic load_pulse;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_meta_reg <= 1'b0;
      cs_sync_reg <= 1'b0;
      cs_prev_reg <= 1'b0;
      word_meta_reg <= '0;
      word_sync_reg <= '0;
    end else begin
      cs_meta_reg <= chip_select;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      word_meta_reg <= frame_word;
      word_sync_reg <= word_meta_reg;
    end
  end

  // (RL8) falling load pulse
  assign load_pulse = cs_prev_reg & ~cs_sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Frame decode. Last bit in is the third mode bit at position 0.
  logic [2:0] mode_code;
  logic [SEG_W-1:0] seg_word;
  logic [DIM_W-1:0] dim_word;

  // (RL13) segment frame layout
  // (RL9) mode bit order
  assign mode_code = {word_sync_reg[0], word_sync_reg[1], word_sync_reg[2]};
  // First segment bit arrived earliest, so it sits highest; reverse it.
  // (RL17) dimming LSB first
  always_comb begin
    for (int i = 0; i < SEG_W; i++) begin
      seg_word[i] = word_sync_reg[SHIFT_W-1-i];
    end
    for (int j = 0; j < DIM_W; j++) begin
      dim_word[j] = word_sync_reg[3+DIM_W-1-j];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending latches written by load pulses.
  logic [SEG_W-1:0] pend_reg [`VFD_GRIDS];
  logic [SEG_W-1:0] pend_next [`VFD_GRIDS];
  logic [DIM_W-1:0] dim_pend_reg;
  logic [DIM_W-1:0] dim_pend_next;

  always_comb begin
    for (int g = 0; g < `VFD_GRIDS; g++) begin
      pend_next[g] = pend_reg[g];
    end
    dim_pend_next = dim_pend_reg;
    if (load_pulse) begin
      case (mode_code)
        // (RL10) all three latches
        vfd_pkg::mode_all_t: begin
          for (int g = 0; g < `VFD_GRIDS; g++) begin
            pend_next[g] = seg_word;
          end
        end
        // (RL11) single grid only
        vfd_pkg::mode_grid_drive_one_n_t: begin
          pend_next[0] = seg_word;
        end
        vfd_pkg::mode_grid_drive_two_n_t: begin
          pend_next[1] = seg_word;
        end
        vfd_pkg::mode_grid_drive_three_n_t: begin
          pend_next[2] = seg_word;
        end
        vfd_pkg::mode_dim_t: begin
          dim_pend_next = dim_word;
        end
        // (RL19) undefined codes ignored
        default: begin
          dim_pend_next = dim_pend_reg;
        end
      endcase
    end
  end

  // (RL1) clear latches
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int g = 0; g < `VFD_GRIDS; g++) begin
        pend_reg[g] <= `VFD_SEG_RESET;
      end
      dim_pend_reg <= `VFD_DIM_RESET;
    end else begin
      for (int g = 0; g < `VFD_GRIDS; g++) begin
        pend_reg[g] <= pend_next[g];
      end
      dim_pend_reg <= dim_pend_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timing generator: bit time divider, slot counter and slot state.
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [9:0] bit_cnt_reg;
  logic [9:0] bit_cnt_next;
  vfd_pkg::slot_t slot_reg;
  vfd_pkg::slot_t slot_next;
  logic [SEG_W-1:0] active_seg_reg;
  logic [SEG_W-1:0] active_seg_next;
  logic [DIM_W-1:0] active_dim_reg;
  logic [DIM_W-1:0] active_dim_next;
  logic bit_tick;
  logic slot_end;
  logic [DIM_W-1:0] duty;

  assign bit_tick = (div_reg == 2'(`VFD_OSC_PER_BIT - 1));
  assign slot_end = bit_tick && (bit_cnt_reg == 10'(`VFD_SLOT_BITS - 1));

  // (RL18) clamp the duty
  assign duty = (dim_pend_reg >= `VFD_DIM_CLAMP) ? `VFD_DIM_CLAMP : dim_pend_reg;

  always_comb begin
    div_next = bit_tick ? `VFD_BIT_DIV_RESET : div_reg + 2'h1;
    bit_cnt_next = bit_cnt_reg;
    slot_next = slot_reg;
    active_seg_next = active_seg_reg;
    active_dim_next = active_dim_reg;
    if (bit_tick) begin
      bit_cnt_next = bit_cnt_reg + 10'h001;
    end
    // (RL14) three equal slots
    // (RL20) apply at boundary
    if (slot_end) begin
      active_dim_next = duty;
      case (slot_reg)
        vfd_pkg::slot_one_t: begin
          slot_next = vfd_pkg::slot_two_t;
          active_seg_next = pend_reg[1];
        end
        vfd_pkg::slot_two_t: begin
          slot_next = vfd_pkg::slot_three_t;
          active_seg_next = pend_reg[2];
        end
        vfd_pkg::slot_three_t: begin
          slot_next = vfd_pkg::slot_one_t;
          active_seg_next = pend_reg[0];
        end
        default: begin
          slot_next = vfd_pkg::slot_one_t;
          active_seg_next = pend_reg[0];
        end
      endcase
    end
  end

  // (RL2) zero duty after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_reg <= `VFD_BIT_DIV_RESET;
      bit_cnt_reg <= 10'h000;
      slot_reg <= vfd_pkg::slot_one_t;
      active_seg_reg <= `VFD_SEG_RESET;
      active_dim_reg <= `VFD_DIM_RESET;
    end else begin
      div_reg <= div_next;
      bit_cnt_reg <= bit_cnt_next;
      slot_reg <= slot_next;
      active_seg_reg <= active_seg_next;
      active_dim_reg <= active_dim_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage, registered. Grid one stays selected (low) whenever its
  // slot runs, matching the reset picture; segments are gated by duty.
  logic on_time;
  logic [SEG_W-1:0] anode_next;
  logic g1_next;
  logic g2_next;
  logic g3_next;
  logic dimming_pulse_out_next;

  // (RL15) on-time equals value
  // (RL16) low value short pulse
  assign on_time = (bit_cnt_reg < 10'(active_dim_reg));

  always_comb begin
    // (RL12) lit when bit set
    anode_next = on_time ? active_seg_reg : '0;
    g1_next = ~(slot_reg == vfd_pkg::slot_one_t);
    g2_next = ~(slot_reg == vfd_pkg::slot_two_t);
    g3_next = ~(slot_reg == vfd_pkg::slot_three_t);
    dimming_pulse_out_next = on_time;
  end

  // (RL3) segments low
  // (RL4) grid one low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      anode_out <= `VFD_SEG_RESET;
      grid_drive_one_n <= 1'b0;
      grid_drive_two_n <= 1'b1;
      grid_drive_three_n <= 1'b1;
      dimming_pulse_out <= 1'b0;
      slot_sync_out_a <= 1'b0;
      slot_sync_out_b <= 1'b0;
      dim_level <= `VFD_DIM_RESET;
    end else begin
      anode_out <= anode_next;
      grid_drive_one_n <= g1_next;
      grid_drive_two_n <= g2_next;
      grid_drive_three_n <= g3_next;
      dimming_pulse_out <= dimming_pulse_out_next;
      slot_sync_out_a <= slot_reg[0];
      slot_sync_out_b <= slot_reg[1];
      dim_level <= dim_pend_reg;
    end
  end

endmodule

// File: dv/vfd_driver_chk.sv
/* Assertions on the display driver outputs.
   Assumes a bind onto vfd_driver; all outputs registered on clock. */
`timescale 1ns/1ps
module vfd_driver_chk #(
  parameter int SEG_W = 32,
  parameter int DIM_W = 10
) (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Reset.
  input wire logic chip_select, // Link window.
  input wire logic [SEG_W-1:0] anode_out, // Segments.
  input wire logic grid_drive_one_n, // Grid one.
  input wire logic grid_drive_two_n, // Grid two.
  input wire logic grid_drive_three_n, // Grid three.
  input wire logic dimming_pulse_out, // On-time.
  input wire logic slot_sync_out_a, // Slot code a.
  input wire logic slot_sync_out_b, // Slot code b.
  input wire logic [DIM_W-1:0] dim_level // Dimming latch.
);
  logic [2:0] grids, grids_reg;
  logic [12:0] age_reg, age_next, run_reg, run_next;
  logic seen_reg, seen_next, moved;
  assign grids = {grid_drive_three_n, grid_drive_two_n, grid_drive_one_n};
  assign moved = grids != grids_reg;
  // Slot age and unbroken on-time in clocks; the first slot is not timed.
  always_comb begin
    age_next = moved ? 13'h0000 : age_reg + 13'h0001;
    run_next = dimming_pulse_out ? run_reg + 13'h0001 : 13'h0000;
    seen_next = seen_reg | moved;
  end
  always_ff @(posedge clock) begin
    grids_reg <= sys_rst ? 3'h6 : grids;
    age_reg <= sys_rst ? 13'h0000 : age_next;
    run_reg <= sys_rst ? 13'h0000 : run_next;
    seen_reg <= sys_rst ? 1'b0 : seen_next;
  end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property (disable iff (1'b0)
    sys_rst |=> anode_out == '0 && grids == 3'h6 && dim_level == '0 && !dimming_pulse_out)
    else $error("Outputs not in reset state.");
  a_one_grid: assert property ($onehot(~grids))
    else $error("Grid drive not one-hot.");
  a_slot_order: assert property (moved |-> {grids_reg, grids} inside {6'h35, 6'h2B, 6'h1E})
    else $error("Grid slot out of order.");
  a_slot_length: assert property (moved && seen_reg |-> age_reg == 13'h0FFF)
    else $error("Grid slot length wrong.");
  a_sync_code: assert property ({slot_sync_out_a, slot_sync_out_b} ==
    (!grid_drive_one_n ? 2'h0 : !grid_drive_two_n ? 2'h2 : 2'h3))
    else $error("Slot code does not match grid.");
  a_dark_off: assert property (!dimming_pulse_out |-> anode_out == '0)
    else $error("Segment lit outside on-time.");
  a_on_clamp: assert property (run_reg <= 13'h0FE0)
    else $error("On-time above clamp.");
  a_pulse_start: assert property ($rose(dimming_pulse_out) |-> moved || age_reg == 13'h0000)
    else $error("On-time not at slot start.");
  a_load_closed: assert property ($changed(dim_level) |-> !chip_select)
    else $error("Dimming latch changed in open window.");
  a_anode_hold: assert property (dimming_pulse_out && $past(dimming_pulse_out) |-> $stable(anode_out))
    else $error("Segments changed within on-time.");
endmodule
bind vfd_driver vfd_driver_chk #(.SEG_W(SEG_W), .DIM_W(DIM_W)) vfd_driver_chk_i (.clock(clock),
  .sys_rst(sys_rst), .chip_select(chip_select), .anode_out(anode_out), .grid_drive_one_n(grid_drive_one_n),
  .grid_drive_two_n(grid_drive_two_n), .grid_drive_three_n(grid_drive_three_n),
  .dimming_pulse_out(dimming_pulse_out), .slot_sync_out_a(slot_sync_out_a),
  .slot_sync_out_b(slot_sync_out_b), .dim_level(dim_level));

// File: dv/vfd_host_model.sv
/* Host side of the three-wire write link.
   Assumes the bench calls send_frame; the shift clock runs only when sending. */
`timescale 1ns/1ps
module vfd_host_model (
  output logic shift_clock, // Link shift clock.
  output logic chip_select, // Transfer window.
  output logic data_in // Serial data.
);
  initial begin
    shift_clock = 1'b0;
    chip_select = 1'b0;
    data_in = 1'b1;
  end
  // Sends the low n bits of word, bit zero first.
  task automatic send_frame(input logic [34:0] word, input int n);
    // pulses with the window shut, which the receiver must ignore.
    repeat (3) begin
      data_in = ~data_in;
      #6 shift_clock = 1'b1;
      #6 shift_clock = 1'b0;
    end
    #250 chip_select = 1'b1;
    // payload then mode bits, no gap.
    // Data moves with the falling edge, giving half a 12 ns period of setup and of hold.
    for (int i = 0; i < n; i++) begin
      data_in = word[i];
      #6 shift_clock = 1'b1;
      #6 shift_clock = 1'b0;
    end
    // Clock stops well before the window closes, then data is released.
    #30 chip_select = 1'b0;
    data_in = ~data_in;
    #400;
  endtask
endmodule

// File: dv/test_vfd_driver.sv
/* Self-checking bench: frames, latches, grid slots and duty.
   Assumes the host model drives the link; expectations come from functions. */
`timescale 1ns/1ps
`include "vfd_defines.svh"
module test_vfd_driver;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic shift_clock, chip_select, data_in, pulse, sync_a, sync_b;
  wire [2:0] grids;
  logic [9:0] dim_r;
  logic [31:0] anode_out, pat_a, pat_b, pat_c;
  logic [31:0] rng = 32'h0000_6135;
  logic [9:0] dim_level;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  vfd_host_model vfd_host_model_i (.shift_clock(shift_clock), .chip_select(chip_select), .data_in(data_in));
  vfd_driver vfd_driver_i (.clock(clock), .sys_rst(sys_rst), .shift_clock(shift_clock),
    .chip_select(chip_select), .data_in(data_in), .anode_out(anode_out), .grid_drive_one_n(grids[0]),
    .grid_drive_two_n(grids[1]), .grid_drive_three_n(grids[2]), .dimming_pulse_out(pulse),
    .slot_sync_out_a(sync_a), .slot_sync_out_b(sync_b), .dim_level(dim_level));
  ////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Clocks of on-time per slot; large values clamp to leave an off gap.
  function automatic int on_clocks(input logic [9:0] d);
    return int'((d >= `VFD_DIM_CLAMP) ? `VFD_DIM_CLAMP : d) * `VFD_OSC_PER_BIT;
  endfunction
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits for slot s, then measures on-time and lit segments over the slot.
  task automatic watch_slot(input int s, input logic [31:0] seg, input logic [9:0] d);
    int on;
    logic [31:0] lit;
    on = 0;
    lit = 32'h0000_0000;
    #1;
    while (grids !== ~(3'h1 << s)) begin
      @(posedge clock);
      #1;
    end
    check_val("slot code", (s == 0) ? 32'h0000_0000 : (s == 1) ? 32'h0000_0002 : 32'h0000_0003, {30'h0, sync_a, sync_b});
    repeat (`VFD_SLOT_BITS * `VFD_OSC_PER_BIT) begin
      if (pulse === 1'b1) begin
        on++;
        lit |= anode_out;
      end
      @(posedge clock);
      #1;
    end
    check_val("on time", on_clocks(d), on);
    check_val("lit segments", (d == 10'h000) ? 32'h0000_0000 : seg, lit);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 48000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check_val("reset anodes", 32'h0000_0000, anode_out);
    check_val("reset grids", 32'h0000_0006, {29'h0, grids});
    check_val("reset dim", 32'h0000_0000, {22'h0, dim_level});
    check_val("reset sync", 32'h0000_0000, {30'h0, sync_a, sync_b});
    vfd_host_model_i.send_frame({22'h0, vfd_pkg::mode_dim_t, 10'h040}, 13);
    check_val("dim load", 32'h0000_0040, {22'h0, dim_level});
    pat_a = next_rand();
    pat_b = next_rand();
    pat_c = next_rand();
    vfd_host_model_i.send_frame({vfd_pkg::mode_all_t, pat_a}, 35);
    vfd_host_model_i.send_frame({vfd_pkg::mode_grid_drive_two_n_t, pat_b}, 35);
    for (int m = 5; m < 8; m++)
      vfd_host_model_i.send_frame({m[2:0], next_rand()}, 35);
    check_val("dim kept", 32'h0000_0040, {22'h0, dim_level});
    watch_slot(1, pat_b, 10'h040);
    watch_slot(2, pat_a, 10'h040);
    watch_slot(0, pat_a, 10'h040);
    pat_a = next_rand();
    vfd_host_model_i.send_frame({22'h0, vfd_pkg::mode_dim_t, 10'h3FF}, 13);
    check_val("dim raw", 32'h0000_03FF, {22'h0, dim_level});
    vfd_host_model_i.send_frame({vfd_pkg::mode_grid_drive_three_n_t, pat_a}, 35);
    vfd_host_model_i.send_frame({vfd_pkg::mode_grid_drive_one_n_t, pat_c}, 35);
    watch_slot(2, pat_a, 10'h3FF);
    watch_slot(0, pat_c, 10'h3FF);
    // A random duty, which may land on zero or in the clamped range.
    pat_b = next_rand();
    dim_r = pat_b[9:0];
    vfd_host_model_i.send_frame({22'h0, vfd_pkg::mode_dim_t, dim_r}, 13);
    check_val("dim random", {22'h0, dim_r}, {22'h0, dim_level});
    watch_slot(2, pat_a, dim_r);
    complete_run();
  end
endmodule
